// >>> logic/tap_regs_pkg.sv
package tap_regs_pkg;
	localparam int IR_WIDTH = 8;
	localparam int ID_WIDTH = 32;
	localparam int BSR_WIDTH = 121;
	localparam logic [7:0] INSTR_EXTEST = 8'h00;
	localparam logic [7:0] INSTR_IDENTIFY = 8'h21;
	localparam logic [7:0] INSTR_SNAPSHOT = 8'h05;
	localparam logic [7:0] INSTR_HOLD = 8'h07;
	localparam logic [7:0] INSTR_FLOAT = 8'h03;
	localparam logic [7:0] INSTR_BYPASS = 8'hff;
	localparam logic [1:0] IR_CAPTURE_LOW = 2'h1;
	// Identity value is arbitrary; bit 0 marks presence of the register
	localparam logic [31:0] ID_VALUE_DEFAULT = 32'h1234_5679;
	localparam int TCK_MIN_PERIOD_NS = 20;
	localparam int SYS_PERIOD_NS = 40;
	typedef enum logic [1:0] {
		SEL_BYPASS_type_e = 2'h0,
		SEL_IDENT = 2'h1,
		SEL_BOUNDARY = 2'h3
	} path_select_type;
	typedef enum logic [3:0] {
		ST_RESET   = 4'h0,
		ST_IDLE    = 4'h1,
		ST_SEL_DR  = 4'h3,
		ST_CAP_DR  = 4'h2,
		ST_SHF_DR  = 4'h6,
		ST_EX1_DR  = 4'h7,
		ST_PAU_DR  = 4'h5,
		ST_EX2_DR  = 4'h4,
		ST_UPD_DR  = 4'hc,
		ST_SEL_IR  = 4'hd,
		ST_CAP_IR  = 4'hf,
		ST_SHF_IR  = 4'he,
		ST_EX1_IR  = 4'ha,
		ST_PAU_IR  = 4'hb,
		ST_EX2_IR  = 4'h9,
		ST_UPD_IR  = 4'h8
	} tap_state_type;
endpackage : tap_regs_pkg

// >>> logic/sync_edge.sv
`timescale 1ns/1ns
module sync_edge #(
	parameter int WIDTH = 3
) (
	input  wire logic             clk_sys_in,
	input  wire logic             reset_in,
	input  wire logic [WIDTH-1:0] async_in,
	output logic      [WIDTH-1:0] sync_out
);
	if (WIDTH < 1) begin : g_bad_width
		$error("WIDTH must be at least one");
	end
	logic [WIDTH-1:0] stage1;
	always_ff @(posedge clk_sys_in or posedge reset_in) begin
		if (reset_in) begin
			stage1   <= '0;
			sync_out <= '0;
		end else begin
			stage1   <= async_in;
			sync_out <= stage1;
		end
	end
endmodule : sync_edge

// >>> logic/tap_fsm.sv
`timescale 1ns/1ns
module tap_fsm (
	input  wire logic                         clk_sys_in,
	input  wire logic                         reset_in,
	input  wire logic                         tck_rise_in,
	input  wire logic                         tms_in,
	output tap_regs_pkg::tap_state_type       state_out
);
	tap_regs_pkg::tap_state_type next_state;
	always_comb begin
		next_state = state_out;
		case (state_out)
			tap_regs_pkg::ST_RESET:  next_state = tms_in ? tap_regs_pkg::ST_RESET  : tap_regs_pkg::ST_IDLE;
			tap_regs_pkg::ST_IDLE:   next_state = tms_in ? tap_regs_pkg::ST_SEL_DR : tap_regs_pkg::ST_IDLE;
			tap_regs_pkg::ST_SEL_DR: next_state = tms_in ? tap_regs_pkg::ST_SEL_IR : tap_regs_pkg::ST_CAP_DR;
			tap_regs_pkg::ST_CAP_DR: next_state = tms_in ? tap_regs_pkg::ST_EX1_DR : tap_regs_pkg::ST_SHF_DR;
			tap_regs_pkg::ST_SHF_DR: next_state = tms_in ? tap_regs_pkg::ST_EX1_DR : tap_regs_pkg::ST_SHF_DR;
			tap_regs_pkg::ST_EX1_DR: next_state = tms_in ? tap_regs_pkg::ST_UPD_DR : tap_regs_pkg::ST_PAU_DR;
			tap_regs_pkg::ST_PAU_DR: next_state = tms_in ? tap_regs_pkg::ST_EX2_DR : tap_regs_pkg::ST_PAU_DR;
			tap_regs_pkg::ST_EX2_DR: next_state = tms_in ? tap_regs_pkg::ST_UPD_DR : tap_regs_pkg::ST_SHF_DR;
			tap_regs_pkg::ST_UPD_DR: next_state = tms_in ? tap_regs_pkg::ST_SEL_DR : tap_regs_pkg::ST_IDLE;
			tap_regs_pkg::ST_SEL_IR: next_state = tms_in ? tap_regs_pkg::ST_RESET  : tap_regs_pkg::ST_CAP_IR;
			tap_regs_pkg::ST_CAP_IR: next_state = tms_in ? tap_regs_pkg::ST_EX1_IR : tap_regs_pkg::ST_SHF_IR;
			tap_regs_pkg::ST_SHF_IR: next_state = tms_in ? tap_regs_pkg::ST_EX1_IR : tap_regs_pkg::ST_SHF_IR;
			tap_regs_pkg::ST_EX1_IR: next_state = tms_in ? tap_regs_pkg::ST_UPD_IR : tap_regs_pkg::ST_PAU_IR;
			tap_regs_pkg::ST_PAU_IR: next_state = tms_in ? tap_regs_pkg::ST_EX2_IR : tap_regs_pkg::ST_PAU_IR;
			tap_regs_pkg::ST_EX2_IR: next_state = tms_in ? tap_regs_pkg::ST_UPD_IR : tap_regs_pkg::ST_SHF_IR;
			tap_regs_pkg::ST_UPD_IR: next_state = tms_in ? tap_regs_pkg::ST_SEL_DR : tap_regs_pkg::ST_IDLE;
			default:                 next_state = tap_regs_pkg::ST_RESET;
		endcase
	end
	always_ff @(posedge clk_sys_in or posedge reset_in) begin
		if (reset_in) begin
			state_out <= tap_regs_pkg::ST_RESET;
		end else if (tck_rise_in) begin
			state_out <= next_state;
		end
	end
endmodule : tap_fsm

// >>> logic/boundary_scan_tap_registers.sv
`timescale 1ns/1ns
// Contract
// (RQ1) Exactly one scan register sits between serial in and out, chosen by instruction.
// (RQ2) Serial input sampled on test clock rise, serial output changes on fall.
// (RQ3) Eight-bit instruction register; new instruction takes effect at update-IR.
// (RQ4) Reset and test-logic-reset make identify the active instruction.
// (RQ5) Capture-IR loads binary 01 into the two low instruction bits.
// (RQ6) A one-bit bypass register gives a single-stage path.
// (RQ7) Bypass register is cleared to zero when bypass executes.
// (RQ8) Boundary chain is 121 cells long.
// (RQ9) Capture-DR loads pin states into boundary chain; shift-DR shifts it.
// (RQ10) Serial input feeds the top bit; the bottom bit drives serial out.
// (RQ11) Identify loads a fixed 32-bit identity in capture-DR, shifted out.
// (RQ12) Controller loads no reserved instruction codes; the testbench loads reserved code 5a on purpose.
// (RQ13) Controller shifts instruction in shift-IR and then passes update-IR.
// (RQ14) External test drives chain onto outputs, enabled from update-IR.
// (RQ15) Controller should preload the vector before selecting external test.
// (RQ16) Float outputs selects bypass and puts data outputs into high impedance.
// (RQ17) Hold outputs drives each output from its boundary cell.
// (RQ18) Snapshot captures pins at capture-DR without disturbing normal operation.
// (RQ19) Controller keeps the test clock at or below 50 MHz.
// (RQ20) Controller ignores captured system clock cells if that clock runs.
// (RQ21) Codes: external test 00, identify 21, snapshot 05 hex.
// (RQ22) Codes: hold 07, float 03, bypass ff hex; bypass leaves memory alone.
// (RQ23) Hold outputs selects the bypass register.
// (RQ24) Serial output driven only in shift-IR and shift-DR, otherwise released.
// (RQ25) Reserved codes behave as bypass with pins in normal operation.
module boundary_scan_tap_registers #(
	parameter int          BSR_LEN  = tap_regs_pkg::BSR_WIDTH,
	parameter logic [31:0] ID_VALUE = tap_regs_pkg::ID_VALUE_DEFAULT
) (
	input  wire logic                 clk_sys_in,
	input  wire logic                 reset_in,
	input  wire logic                 tck_in,
	input  wire logic                 tms_in,
	input  wire logic                 tdi_in,
	input  wire logic [BSR_LEN-1:0]   pin_state_in,
	output logic                      tdo_out,
	output logic                      tdo_oe_out,
	output logic [BSR_LEN-1:0]        pin_drive_out,
	output logic                      pin_test_mode_out,
	output logic                      pin_float_out,
	output logic [7:0]                active_instr_out
);
	localparam int TCK_MIN_CYC =
		(tap_regs_pkg::TCK_MIN_PERIOD_NS + tap_regs_pkg::SYS_PERIOD_NS - 1)
		/ tap_regs_pkg::SYS_PERIOD_NS;

	if (BSR_LEN < 2) begin : g_bad_len
		$error("BSR_LEN too small");
	end
	if (TCK_MIN_CYC < 1) begin : g_bad_tck
		$error("bad test clock bound");
	end

	logic [2:0]                  sync_vec;
	logic                        tck_s;
	logic                        tms_s;
	logic                        tdi_s;
	logic                        tck_prev;
	logic                        tck_rise;
	logic                        tck_fall;
	tap_regs_pkg::tap_state_type state;
	logic [7:0]                  ir_shift;
	logic                        skip_bit;
	logic [BSR_LEN-1:0]          chain;
	logic [31:0]                 ident_shift;
	logic                        next_tdo;
	logic [BSR_LEN-1:0]          pin_state_s;

	// Test pins come from another clock domain
	sync_edge #(.WIDTH(3)) u_sync (
		.clk_sys_in (clk_sys_in),
		.reset_in   (reset_in),
		.async_in   ({tck_in, tms_in, tdi_in}),
		.sync_out   (sync_vec)
	);
	assign tck_s = sync_vec[2];
	assign tms_s = sync_vec[1];
	assign tdi_s = sync_vec[0];

	// Ball states are asynchronous too; capture sees them two cycles late
	sync_edge #(.WIDTH(BSR_LEN)) u_pin_sync (
		.clk_sys_in (clk_sys_in),
		.reset_in   (reset_in),
		.async_in   (pin_state_in),
		.sync_out   (pin_state_s)
	);

	always_ff @(posedge clk_sys_in or posedge reset_in) begin
		if (reset_in) begin
			tck_prev <= 1'b0;
		end else begin
			tck_prev <= tck_s;
		end
	end
	assign tck_rise = tck_s & ~tck_prev;
	assign tck_fall = ~tck_s & tck_prev;

	tap_fsm u_fsm (
		.clk_sys_in  (clk_sys_in),
		.reset_in    (reset_in),
		.tck_rise_in (tck_rise),
		.tms_in      (tms_s),
		.state_out   (state)
	);

	function automatic tap_regs_pkg::path_select_type path_of(input logic [7:0] instr);
		case (instr)
			tap_regs_pkg::INSTR_EXTEST,
			tap_regs_pkg::INSTR_SNAPSHOT: path_of = tap_regs_pkg::SEL_BOUNDARY;
			tap_regs_pkg::INSTR_IDENTIFY: path_of = tap_regs_pkg::SEL_IDENT;
			// Hold, float, bypass and reserved codes all use the single bit
			default:                      path_of = tap_regs_pkg::SEL_BYPASS_type_e; // [RQ23] [RQ25]
		endcase
	endfunction : path_of

	// Instruction shift and active instruction
	always_ff @(posedge clk_sys_in or posedge reset_in) begin
		if (reset_in) begin
			ir_shift         <= 8'h00;
			active_instr_out <= tap_regs_pkg::INSTR_IDENTIFY; // [RQ4]
		end else if (tck_rise) begin // [RQ2]
			case (state)
				tap_regs_pkg::ST_RESET: begin
					active_instr_out <= tap_regs_pkg::INSTR_IDENTIFY; // [RQ4]
				end
				tap_regs_pkg::ST_CAP_IR: begin
					ir_shift <= {ir_shift[7:2], tap_regs_pkg::IR_CAPTURE_LOW}; // [RQ5]
				end
				tap_regs_pkg::ST_SHF_IR: begin
					ir_shift <= {tdi_s, ir_shift[7:1]}; // [RQ3] [RQ10]
				end
				tap_regs_pkg::ST_UPD_IR: begin
					active_instr_out <= ir_shift; // [RQ3]
				end
				default: begin
				end
			endcase
		end
	end

	// Data registers
	always_ff @(posedge clk_sys_in or posedge reset_in) begin
		if (reset_in) begin
			skip_bit    <= 1'b0;
			chain       <= '0;
			ident_shift <= 32'h0000_0000;
		end else if (tck_rise) begin
			case (state)
				tap_regs_pkg::ST_CAP_DR: begin
					skip_bit <= 1'b0; // [RQ7]
					if (path_of(active_instr_out) == tap_regs_pkg::SEL_BOUNDARY) begin
						chain <= pin_state_s; // [RQ9] [RQ18]
					end
					if (path_of(active_instr_out) == tap_regs_pkg::SEL_IDENT) begin
						ident_shift <= ID_VALUE; // [RQ11]
					end
				end
				tap_regs_pkg::ST_SHF_DR: begin
					case (path_of(active_instr_out)) // [RQ1]
						tap_regs_pkg::SEL_BOUNDARY: chain <= {tdi_s, chain[BSR_LEN-1:1]}; // [RQ8] [RQ9] [RQ10]
						tap_regs_pkg::SEL_IDENT: ident_shift <= {tdi_s, ident_shift[31:1]}; // [RQ11]
						default: skip_bit <= tdi_s; // [RQ6]
					endcase
				end
				default: begin
				end
			endcase
		end
	end

	// Serial output mux, updated on the falling test clock edge
	always_comb begin
		next_tdo = skip_bit;
		if (state == tap_regs_pkg::ST_SHF_IR) begin
			next_tdo = ir_shift[0]; // [RQ10]
		end else begin
			case (path_of(active_instr_out)) // [RQ1]
				tap_regs_pkg::SEL_BOUNDARY: next_tdo = chain[0];
				tap_regs_pkg::SEL_IDENT:    next_tdo = ident_shift[0];
				default:                    next_tdo = skip_bit;
			endcase
		end
	end

	always_ff @(posedge clk_sys_in or posedge reset_in) begin
		if (reset_in) begin
			tdo_out    <= 1'b0;
			tdo_oe_out <= 1'b0;
		end else if (tck_fall) begin // [RQ2]
			tdo_out    <= next_tdo;
			tdo_oe_out <= (state == tap_regs_pkg::ST_SHF_IR) ||
			              (state == tap_regs_pkg::ST_SHF_DR); // [RQ24]
		end
	end

	// Pin control: outputs follow chain only in external test and hold.
	// Drive register updates at update-DR and update-IR so shifting never glitches pins.
	always_ff @(posedge clk_sys_in or posedge reset_in) begin
		if (reset_in) begin
			pin_drive_out     <= '0;
			pin_test_mode_out <= 1'b0;
			pin_float_out     <= 1'b0;
		end else begin
			pin_test_mode_out <= (active_instr_out == tap_regs_pkg::INSTR_EXTEST) ||
			                     (active_instr_out == tap_regs_pkg::INSTR_HOLD); // [RQ14] [RQ17]
			pin_float_out     <= (active_instr_out == tap_regs_pkg::INSTR_FLOAT); // [RQ16]
			if (tck_rise && (state == tap_regs_pkg::ST_UPD_DR ||
			                 state == tap_regs_pkg::ST_UPD_IR)) begin
				pin_drive_out <= chain; // [RQ14]
			end
		end
	end

	chk_ir_capture_01: assert property (@(posedge clk_sys_in) disable iff (reset_in) // [RQ5]
		(tck_rise && state == tap_regs_pkg::ST_CAP_IR) |=> (ir_shift[1:0] == 2'b01))
		else $error("capture-IR did not load 01");

	chk_reset_identify: assert property (@(posedge clk_sys_in) disable iff (reset_in) // [RQ4]
		(tck_rise && state == tap_regs_pkg::ST_RESET) |=>
		(active_instr_out == tap_regs_pkg::INSTR_IDENTIFY))
		else $error("test-logic-reset did not select identify");

	chk_instr_hold_stable: assert property (@(posedge clk_sys_in) disable iff (reset_in) // [RQ3]
		!(tck_rise && (state == tap_regs_pkg::ST_UPD_IR || state == tap_regs_pkg::ST_RESET))
		|=> $stable(active_instr_out))
		else $error("instruction changed outside update-IR");

	chk_update_loads: assert property (@(posedge clk_sys_in) disable iff (reset_in) // [RQ3]
		(tck_rise && state == tap_regs_pkg::ST_UPD_IR) |=> (active_instr_out == $past(ir_shift)))
		else $error("update-IR did not load instruction");

	chk_tdo_enable: assert property (@(posedge clk_sys_in) disable iff (reset_in) // [RQ24]
		(tck_fall && state != tap_regs_pkg::ST_SHF_IR && state != tap_regs_pkg::ST_SHF_DR)
		|=> !tdo_oe_out)
		else $error("serial output enabled outside shift");

	chk_tdo_on_fall: assert property (@(posedge clk_sys_in) disable iff (reset_in) // [RQ2]
		!tck_fall |=> $stable(tdo_out))
		else $error("serial output changed away from falling edge");

	chk_ident_capture: assert property (@(posedge clk_sys_in) disable iff (reset_in) // [RQ11]
		(tck_rise && state == tap_regs_pkg::ST_CAP_DR &&
		 active_instr_out == tap_regs_pkg::INSTR_IDENTIFY) |=> (ident_shift == ID_VALUE))
		else $error("identity not captured");

	chk_bypass_clear: assert property (@(posedge clk_sys_in) disable iff (reset_in) // [RQ7]
		(tck_rise && state == tap_regs_pkg::ST_CAP_DR) |=> !skip_bit)
		else $error("bypass bit not cleared");

	chk_float_outputs: assert property (@(posedge clk_sys_in) disable iff (reset_in) // [RQ16]
		(active_instr_out == tap_regs_pkg::INSTR_FLOAT) [*2] |-> pin_float_out)
		else $error("float instruction did not release outputs");

	chk_boundary_shift: assert property (@(posedge clk_sys_in) disable iff (reset_in) // [RQ10]
		(tck_rise && state == tap_regs_pkg::ST_SHF_DR &&
		 active_instr_out == tap_regs_pkg::INSTR_SNAPSHOT) |=>
		(chain[BSR_LEN-1] == $past(tdi_s)))
		else $error("serial input did not enter chain top");

	chk_tck_rate: assert property (@(posedge clk_sys_in) disable iff (reset_in) // [RQ19]
		tck_rise |=> (!tck_fall) [*2])
		else $error("test clock high phase too short for sampling");

	chk_oe_in_shift: assert property (@(posedge clk_sys_in) disable iff (reset_in) // [RQ24]
		(tck_fall && (state == tap_regs_pkg::ST_SHF_IR || state == tap_regs_pkg::ST_SHF_DR))
		|=> tdo_oe_out)
		else $error("serial output not enabled in shift");

	chk_ir_lsb_out: assert property (@(posedge clk_sys_in) disable iff (reset_in) // [RQ10]
		(tck_fall && state == tap_regs_pkg::ST_SHF_IR) |=> (tdo_out == $past(ir_shift[0])))
		else $error("instruction bit 0 not on serial output");

	chk_ir_msb_in: assert property (@(posedge clk_sys_in) disable iff (reset_in) // [RQ10]
		(tck_rise && state == tap_regs_pkg::ST_SHF_IR) |=> (ir_shift[7] == $past(tdi_s)))
		else $error("serial input did not enter instruction top");

	chk_ident_msb_in: assert property (@(posedge clk_sys_in) disable iff (reset_in) // [RQ11]
		(tck_rise && state == tap_regs_pkg::ST_SHF_DR &&
		 active_instr_out == tap_regs_pkg::INSTR_IDENTIFY) |=> (ident_shift[31] == $past(tdi_s)))
		else $error("serial input did not enter identity top");

	chk_skip_shift: assert property (@(posedge clk_sys_in) disable iff (reset_in) // [RQ6]
		(tck_rise && state == tap_regs_pkg::ST_SHF_DR &&
		 path_of(active_instr_out) == tap_regs_pkg::SEL_BYPASS_type_e)
		|=> (skip_bit == $past(tdi_s)))
		else $error("bypass bit did not take serial input");

	chk_chain_capture: assert property (@(posedge clk_sys_in) disable iff (reset_in) // [RQ9] [RQ18]
		(tck_rise && state == tap_regs_pkg::ST_CAP_DR &&
		 path_of(active_instr_out) == tap_regs_pkg::SEL_BOUNDARY)
		|=> (chain == $past(pin_state_s)))
		else $error("pin states not captured");

	chk_drive_update: assert property (@(posedge clk_sys_in) disable iff (reset_in) // [RQ14]
		(tck_rise && state == tap_regs_pkg::ST_UPD_DR) |=> (pin_drive_out == $past(chain)))
		else $error("update-DR did not load drive values");

	chk_drive_steady: assert property (@(posedge clk_sys_in) disable iff (reset_in) // [RQ14]
		!(tck_rise && (state == tap_regs_pkg::ST_UPD_DR || state == tap_regs_pkg::ST_UPD_IR))
		|=> $stable(pin_drive_out))
		else $error("drive values changed outside update");

	chk_test_mode: assert property (@(posedge clk_sys_in) disable iff (reset_in) // [RQ14] [RQ17]
		(active_instr_out == tap_regs_pkg::INSTR_EXTEST ||
		 active_instr_out == tap_regs_pkg::INSTR_HOLD) [*2] |-> pin_test_mode_out)
		else $error("outputs not under test control");

	chk_normal_mode: assert property (@(posedge clk_sys_in) disable iff (reset_in) // [RQ25]
		(active_instr_out != tap_regs_pkg::INSTR_EXTEST &&
		 active_instr_out != tap_regs_pkg::INSTR_HOLD &&
		 active_instr_out != tap_regs_pkg::INSTR_FLOAT) [*2]
		|-> (!pin_test_mode_out && !pin_float_out))
		else $error("pins left normal operation");
endmodule : boundary_scan_tap_registers

// >>> verification/jtag_ctl.sv
`timescale 1ns/1ns
module jtag_ctl (
	output logic      tck_out,
	output logic      tms_out,
	output logic      tdi_out,
	input  wire logic tdo_in,
	input  wire logic tdo_oe_in
);
	// 320 ns period, far slower than the 20 ns minimum
	localparam int HALF_NS = 160;

	initial begin
		tck_out = 1'b0;
		tms_out = 1'b1;
		tdi_out = 1'b1;
	end

	// Clock stands low between calls; serial out is read late in the high phase
	task automatic step(input logic tms_v, input logic tdi_v, output logic tdo_v,
			output logic oe_v);
		tms_out = tms_v;
		tdi_out = tdi_v;
		#HALF_NS tck_out = 1'b1;
		#(HALF_NS - 10);
		oe_v = tdo_oe_in;
		// A released serial out is never trusted
		tdo_v = tdo_oe_in ? tdo_in : 1'bz;
		#10 tck_out = 1'b0;
	endtask : step

	task automatic walk(input logic tms_v, inout logic ok);
		logic d;
		logic o;
		step(tms_v, 1'b1, d, o);
		ok &= (o === 1'b0);
	endtask : walk

	task automatic shift(input int n, input logic [159:0] din, output logic [159:0] dout,
			inout logic ok);
		logic o;
		dout = '0;
		for (int i = 0; i < n; i++) begin
			step(i == n - 1, din[i], dout[i], o);
			ok &= (o === 1'b1);
		end
	endtask : shift

	// Five high mode edges reach test-logic-reset, one low edge parks in idle
	task automatic tap_reset;
		logic ok;
		ok = 1'b1;
		repeat (5) walk(1'b1, ok);
		walk(1'b0, ok);
	endtask : tap_reset

	// Instruction goes in through shift-IR and waits in exit1 for update
	task automatic ir_shift(input logic [7:0] code, output logic [7:0] cap, output logic ok);
		logic [159:0] q;
		ok = 1'b1;
		walk(1'b1, ok);
		walk(1'b1, ok);
		walk(1'b0, ok);
		walk(1'b0, ok);
		shift(8, {152'h0, code}, q, ok);
		cap = q[7:0];
	endtask : ir_shift

	task automatic dr_shift(input int n, input logic [159:0] din, output logic [159:0] dout,
			output logic ok);
		ok = 1'b1;
		walk(1'b1, ok);
		walk(1'b0, ok);
		walk(1'b0, ok);
		shift(n, din, dout, ok);
	endtask : dr_shift

	task automatic upd;
		logic ok;
		ok = 1'b1;
		walk(1'b1, ok);
		walk(1'b0, ok);
	endtask : upd
endmodule : jtag_ctl

// >>> verification/boundary_scan_tap_registers_tb.sv
`timescale 1ns/1ns
module boundary_scan_tap_registers_tb;
	localparam int          L     = tap_regs_pkg::BSR_WIDTH;
	localparam int          N     = 160;
	// Arbitrary identity value, bit 0 set as presence marker
	localparam logic [31:0] ID_TB = 32'ha5c3_0f01;
	typedef struct {
		logic [7:0]   code;
		int           len;
		logic [159:0] cap;
		logic         mode;
		logic         flt;
	} row_type;
	logic           clk_sys_in = 1'b0;
	logic           reset_in;
	logic           tck;
	logic           tms;
	logic           tdi;
	logic [L-1:0]   pins;
	logic           tdo;
	logic           tdo_oe;
	logic [L-1:0]   drv;
	logic           mode;
	logic           flt;
	logic [7:0]     active;
	logic [7:0]     cur_instr;
	logic [L-1:0]   exp_drv;
	logic [159:0]   pat = {5{32'h9e37_79b9}};
	row_type        rows [7];
	int             err_total = 0;
	int             total_checks = 0;

	always #20 clk_sys_in = ~clk_sys_in;

	jtag_ctl ctl (.tck_out(tck), .tms_out(tms), .tdi_out(tdi), .tdo_in(tdo), .tdo_oe_in(tdo_oe));

	boundary_scan_tap_registers #(.BSR_LEN(L), .ID_VALUE(ID_TB)) dut (
		.clk_sys_in(clk_sys_in), .reset_in(reset_in), .tck_in(tck), .tms_in(tms),
		.tdi_in(tdi), .pin_state_in(pins), .tdo_out(tdo), .tdo_oe_out(tdo_oe),
		.pin_drive_out(drv), .pin_test_mode_out(mode), .pin_float_out(flt),
		.active_instr_out(active));

	task automatic check(input logic [159:0] seen, input logic [159:0] exp, input string msg);
		total_checks++;
		if (seen !== exp) begin
			err_total++;
			$display("mismatch at %0t: %s", $time, msg);
		end
	endtask : check

	task automatic finish_test;
		$display("checks %0d mismatches %0d", total_checks, err_total);
		if (err_total == 0 && total_checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : finish_test

	// Bits before the register length are the captured value, then the input returns
	function automatic logic [159:0] exp_out(input logic [159:0] cap, input int len,
			input logic [159:0] din);
		logic [159:0] e;
		for (int i = 0; i < N; i++) e[i] = (i < len) ? cap[i] : din[i - len];
		return e;
	endfunction : exp_out

	task automatic settle;
		repeat (10) @(negedge clk_sys_in);
	endtask : settle

	task automatic run_row(input int r);
		logic [7:0]   cap;
		logic [159:0] q;
		logic [127:0] t;
		logic         ok;
		@(negedge clk_sys_in);
		// Pins held steady across capture so every cell is meaningful
		t = {4{32'hc3a5_0f96 ^ 32'(r)}};
		pins = t[L-1:0];
		ctl.ir_shift(rows[r].code, cap, ok);
		check(cap[1:0], 2'b01, "ir capture");
		check(ok, 1'b1, "ir enable");
		settle();
		check(active, cur_instr, "early instr");
		ctl.upd();
		settle();
		check(active, rows[r].code, "instr");
		check({mode, flt}, {rows[r].mode, rows[r].flt}, "pin mode");
		check(tdo_oe, 1'b0, "idle enable");
		if (rows[r].mode) check(drv, exp_drv, "drive at ir");
		ctl.dr_shift(N, pat, q, ok);
		check(q, exp_out(rows[r].len == L ? {39'h0, pins} : rows[r].cap, rows[r].len, pat),
			"dr path");
		check(ok, 1'b1, "dr enable");
		ctl.upd();
		settle();
		if (rows[r].len == L) exp_drv = pat[N-1 -: L];
		if (rows[r].mode) check(drv, exp_drv, "drive at dr");
		cur_instr = rows[r].code;
		$display("test row %0d done", r);
	endtask : run_row

	initial begin
		#2_000_000;
		err_total++;
		finish_test();
	end

	initial begin
		// Preload with snapshot before external
		rows[0] = '{tap_regs_pkg::INSTR_SNAPSHOT, L, '0, 1'b0, 1'b0};
		rows[1] = '{tap_regs_pkg::INSTR_EXTEST, L, '0, 1'b1, 1'b0};
		rows[2] = '{tap_regs_pkg::INSTR_HOLD, 1, '0, 1'b1, 1'b0};
		rows[3] = '{tap_regs_pkg::INSTR_FLOAT, 1, '0, 1'b0, 1'b1};
		rows[4] = '{tap_regs_pkg::INSTR_BYPASS, 1, '0, 1'b0, 1'b0};
		// Reserved code sent on purpose to see the fallback
		rows[5] = '{8'h5a, 1, '0, 1'b0, 1'b0};
		rows[6] = '{tap_regs_pkg::INSTR_IDENTIFY, 32, {128'h0, ID_TB}, 1'b0, 1'b0};
		reset_in = 1'b1;
		pins = '0;
		exp_drv = '0;
		cur_instr = 8'h21;
		repeat (3) @(negedge clk_sys_in);
		reset_in = 1'b0;
		repeat (3) @(negedge clk_sys_in);
		check(active, 8'h21, "power-up instr");
		// Reset leaves the port in test-logic-reset; park it in idle first
		ctl.tap_reset();
		for (int r = 0; r < 7; r++) run_row(r);
		run_row(2);
		ctl.tap_reset();
		settle();
		check({active, mode}, {8'h21, 1'b0}, "tms reset");
		$display("test tms reset done");
		cur_instr = 8'h21;
		run_row(3);
		@(negedge clk_sys_in);
		reset_in = 1'b1;
		repeat (3) @(negedge clk_sys_in);
		check({active, flt, tdo_oe}, {8'h21, 2'b00}, "async reset");
		reset_in = 1'b0;
		repeat (3) @(negedge clk_sys_in);
		ctl.tap_reset();
		cur_instr = 8'h21;
		$display("test async reset done");
		run_row(6);
		finish_test();
	end
endmodule : boundary_scan_tap_registers_tb
